// ### pkg/rcrb_map.svh
// register offsets, field positions and reset values of the receiver control bank
`ifndef RCRB_MAP_SVH
`define RCRB_MAP_SVH
// What this block does
// - pin asserted: full power-down if external mode bit 0, standby if 1
// - link logic enters standby on pin only with link standby and external standby bits
// - link power field: 00 normal, 01 power-down pll off, 10 standby pll on
// - converter power field: 00 normal, 01 power-down, 10 standby
// - output disable bit suppresses converter output data
// - data invert bit inverts converter output data
// - format field 00 gives offset binary, 01 twos complement
// - realign-on-sync-request bit realigns link on each sync request assertion
// - realign-on-sysref bit realigns link on each sysref assertion
// - sysref mode 0 resets dividers every assertion, 1 only next rising edge
// - enable bits gate the sysref input and the sync request buffer
// - noise shaper bandwidth bit selects 22% mode at 0, 33% at 1
// - noise shaper processes data only while its enable bit is high
// - six-bit tuning word: 57 valid codes in 22% mode, 34 in 33%
// - dc freeze bit stops updating and holds the last dc estimate
// - dc bandwidth code k sets averaging 2^(-k-14); codes 14 and 15 act as 13
// - dc correction enable adds the correction value to the data path
// - 16-bit dc correction value read as low byte and high byte
// - flag pin function bit: 0 fast detect, 1 overrange indicator
// - force bit drives the flag pin to the forced-value bit
// - fast detect enable lets the upper threshold comparator drive the pin
// - flag sets when magnitude exceeds the 15-bit upper threshold
// - flag clears after magnitude stays below lower threshold for dwell cycles

// ---------------------------------------------------------------------
// offsets
// ---------------------------------------------------------------------
`define RCRB_A_PWR  8'h08
`define RCRB_A_FMT  8'h14
`define RCRB_A_SYN  8'h3a
`define RCRB_A_NSC  8'h3c
`define RCRB_A_NST  8'h3e
`define RCRB_A_DCC  8'h40
`define RCRB_A_DCL  8'h41
`define RCRB_A_DCH  8'h42
`define RCRB_A_FDC  8'h45
`define RCRB_A_SCR  8'h77
`define RCRB_A_SUM  8'h79
`define RCRB_A_DRV  8'h80
`define RCRB_A_MFO  8'h8b
`define RCRB_A_EMP  8'ha8
`define RCRB_A_UPD  8'hff
// staged register slots
`define RCRB_N   11
`define RCRB_I_PWR 4'h0
`define RCRB_I_FMT 4'h1
`define RCRB_I_SYN 4'h2
`define RCRB_I_NSC 4'h3
`define RCRB_I_NST 4'h4
`define RCRB_I_DCC 4'h5
`define RCRB_I_FDC 4'h6
`define RCRB_I_SCR 4'h7
`define RCRB_I_DRV 4'h8
`define RCRB_I_MFO 4'h9
`define RCRB_I_EMP 4'ha
// ---------------------------------------------------------------------
// fields and codes
// ---------------------------------------------------------------------
`define RCRB_B_EXTSB  5
`define RCRB_B_LNKSB  4
`define RCRB_B_DIS    4
`define RCRB_B_INV    2
`define RCRB_B_RLSY   4
`define RCRB_B_RLSR   3
`define RCRB_B_SRMODE 2
`define RCRB_B_SREN   1
`define RCRB_B_SYEN   0
`define RCRB_B_NSWIDE 1
`define RCRB_B_NSEN   0
`define RCRB_B_FRZ    6
`define RCRB_B_DCEN   1
`define RCRB_B_FUNC   4
`define RCRB_B_FRC    3
`define RCRB_B_FVAL   2
`define RCRB_B_FDEN   0
`define RCRB_B_DRVPD  1
`define RCRB_B_XFER   0
`define RCRB_PM_PD    2'b01
`define RCRB_PM_SB    2'b10
`define RCRB_FMT_TWOS 2'b01
`define RCRB_K_MAX    4'd13
`define RCRB_K_BASE   6'd14
`define RCRB_NS_N22   6'd57
`define RCRB_NS_N33   6'd34
`define RCRB_R_EMP    8'h04
`define RCRB_R_ZERO   8'h00
`endif

// ### pkg/rcrb_pkg.sv
// types of the receiver control register bank
`default_nettype none
package rcrb_pkg;
  typedef logic [7:0] rcrb_byte_t;
  typedef struct packed {
    rcrb_byte_t [10:0] stg;
    rcrb_byte_t [10:0] act;
    logic signed [43:0] acc;
    logic [15:0]        corr;
    logic [15:0]        dat;
    logic               den;
    logic               fd;
    logic               pin;
    logic [15:0]        dwl;
    logic               sr_q;
    logic               sy_q;
    logic               armed;
    logic               rlg;
    logic               drst;
    logic [7:0]         rd;
    logic               rv;
    logic               pd_adc;
    logic               sb_adc;
    logic               lk_pll;
    logic               lk_ser;
    logic               lk_rst;
    logic               ns_ok;
    logic [7:0]         sum;
  } rcrb_state_s;
endpackage
`default_nettype wire

// ### verilog/rcrb_top.sv
// receiver control register bank with power, format, dc, sync and flag logic
`include "rcrb_map.svh"
`default_nettype none
module rcrb_top (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // register access
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // pins and timing inputs
  input  wire logic        power_down_pin_i,
  input  wire logic        sysref_i,
  input  wire logic        sync_request_n_i,
  // converter data and detection
  input  wire logic [15:0] sample_i,
  input  wire logic        overrange_i,
  input  wire logic [14:0] thr_upper_i,
  input  wire logic [14:0] thr_lower_i,
  input  wire logic [15:0] dwell_i,
  output logic      [15:0] sample_o,
  output logic             sample_en_o,
  output logic             threshold_flag_pin_o,
  // power control
  output logic             adc_power_down_o,
  output logic             adc_standby_o,
  output logic             link_pll_en_o,
  output logic             link_ser_en_o,
  output logic             link_clk_en_o,
  output logic             link_rst_o,
  output logic             driver_power_down_o,
  // link control
  output logic             link_realign_o,
  output logic             divider_reset_o,
  output logic      [2:0]  cs_assign_o,
  output logic      [4:0]  multiframe_phase_offset_o,
  output logic      [7:0]  emphasis_o,
  // noise shaper control
  output logic             noise_shaper_en_o,
  output logic             noise_shaper_wide_o,
  output logic      [5:0]  noise_shaper_tune_o,
  output logic             noise_shaper_tune_ok_o
);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [4:0] rcrb_dec(input logic [7:0] a);
    case (a)
      `RCRB_A_PWR: rcrb_dec = {1'b1, `RCRB_I_PWR};
      `RCRB_A_FMT: rcrb_dec = {1'b1, `RCRB_I_FMT};
      `RCRB_A_SYN: rcrb_dec = {1'b1, `RCRB_I_SYN};
      `RCRB_A_NSC: rcrb_dec = {1'b1, `RCRB_I_NSC};
      `RCRB_A_NST: rcrb_dec = {1'b1, `RCRB_I_NST};
      `RCRB_A_DCC: rcrb_dec = {1'b1, `RCRB_I_DCC};
      `RCRB_A_FDC: rcrb_dec = {1'b1, `RCRB_I_FDC};
      `RCRB_A_SCR: rcrb_dec = {1'b1, `RCRB_I_SCR};
      `RCRB_A_DRV: rcrb_dec = {1'b1, `RCRB_I_DRV};
      `RCRB_A_MFO: rcrb_dec = {1'b1, `RCRB_I_MFO};
      `RCRB_A_EMP: rcrb_dec = {1'b1, `RCRB_I_EMP};
      default:     rcrb_dec = 5'h00;
    endcase
  endfunction

  // most negative code saturates so the flag compare never wraps
  function automatic logic [14:0] rcrb_mag(input logic [15:0] v);
    if (v == 16'h8000) begin
      rcrb_mag = 15'h7fff;
    end else if (v[15]) begin
      rcrb_mag = 15'(16'h0000 - v);
    end else begin
      rcrb_mag = v[14:0];
    end
  endfunction

  function automatic logic [3:0] rcrb_kclip(input logic [3:0] k);
    rcrb_kclip = (k > `RCRB_K_MAX) ? `RCRB_K_MAX : k;
  endfunction

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  rcrb_pkg::rcrb_state_s r_reg;
  rcrb_pkg::rcrb_state_s r_next;

  logic [7:0]         pwr_w;
  logic [7:0]         fmt_w;
  logic [7:0]         syn_w;
  logic [7:0]         dcc_w;
  logic [7:0]         fdc_w;
  logic [4:0]         dec_w;
  logic               upd_w;
  logic               sr_w;
  logic               sy_w;
  logic               sr_rise_w;
  logic [14:0]        mag_w;
  logic [15:0]        corr_w;
  logic               frc_w;
  logic               fval_w;
  logic [15:0]        y_w;

  assign pwr_w     = r_reg.act[`RCRB_I_PWR];
  assign fmt_w     = r_reg.act[`RCRB_I_FMT];
  assign syn_w     = r_reg.act[`RCRB_I_SYN];
  assign dcc_w     = r_reg.act[`RCRB_I_DCC];
  assign fdc_w     = r_reg.act[`RCRB_I_FDC];
  assign dec_w     = rcrb_dec(reg_addr_i);
  assign upd_w     = reg_wr_i && (reg_addr_i == `RCRB_A_UPD) && reg_wdata_i[`RCRB_B_XFER];
  assign sr_w      = sysref_i && syn_w[`RCRB_B_SREN];
  assign sy_w      = !sync_request_n_i && syn_w[`RCRB_B_SYEN];
  assign sr_rise_w = sr_w && !r_reg.sr_q;
  assign corr_w    = r_reg.corr;
  assign frc_w     = fdc_w[`RCRB_B_FRC];
  assign fval_w    = fdc_w[`RCRB_B_FVAL];
  assign y_w       = dcc_w[`RCRB_B_DCEN] ? sample_i + r_reg.corr : sample_i;
  assign mag_w     = rcrb_mag(y_w);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic        pin_pd;
    logic        pin_sb;
    logic        lk_pd;
    logic        lk_sb;
    logic [3:0]  k;
    logic [4:0]  sh;
    logic signed [43:0] diff;
    logic [15:0] o;
    pin_pd = 1'b0;
    pin_sb = 1'b0;
    lk_pd  = 1'b0;
    lk_sb  = 1'b0;
    k      = 4'h0;
    sh     = 5'h00;
    diff   = 44'sh0;
    o      = 16'h0000;
    r_next      = r_reg;
    r_next.rv   = 1'b0;
    r_next.rd   = 8'h00;
    r_next.rlg  = 1'b0;
    r_next.drst = 1'b0;

    // register reads: staged values, live dc value and checksum
    if (reg_rd_i) begin
      r_next.rv = 1'b1;
      if (dec_w[4]) begin
        r_next.rd = r_reg.stg[dec_w[3:0]];
      end else begin
        case (reg_addr_i)
          `RCRB_A_DCL: r_next.rd = r_reg.corr[7:0];
          `RCRB_A_DCH: r_next.rd = r_reg.corr[15:8];
          `RCRB_A_SUM: r_next.rd = r_reg.sum;
          default:     r_next.rd = 8'h00;
        endcase
      end
    end

    // power modes, pin against register fields
    pin_pd = power_down_pin_i && !pwr_w[`RCRB_B_EXTSB];
    pin_sb = power_down_pin_i && pwr_w[`RCRB_B_EXTSB];
    r_next.pd_adc = pin_pd || (pwr_w[1:0] == `RCRB_PM_PD);
    r_next.sb_adc = !r_next.pd_adc && (pin_sb || (pwr_w[1:0] == `RCRB_PM_SB));
    lk_pd = pin_pd || (pwr_w[3:2] == `RCRB_PM_PD);
    lk_sb = !lk_pd && ((pin_sb && pwr_w[`RCRB_B_LNKSB]) || (pwr_w[3:2] == `RCRB_PM_SB));
    r_next.lk_pll = !lk_pd;
    r_next.lk_ser = !(lk_pd || lk_sb);
    r_next.lk_rst = lk_pd || lk_sb;

    // sysref and sync request
    r_next.sr_q = sr_w;
    r_next.sy_q = sy_w;
    if (sr_rise_w && syn_w[`RCRB_B_RLSR]) begin
      r_next.rlg = 1'b1;
    end
    if (sy_w && !r_reg.sy_q && syn_w[`RCRB_B_RLSY]) begin
      r_next.rlg = 1'b1;
    end
    if (sr_rise_w) begin
      if (!syn_w[`RCRB_B_SRMODE]) begin
        r_next.drst = 1'b1;
      end else if (r_reg.armed) begin
        r_next.drst  = 1'b1;
        r_next.armed = 1'b0;
      end
    end

    // dc estimate: first-order average with shift k+14
    k    = rcrb_kclip(dcc_w[5:2]);
    sh   = 5'(k) + 5'(`RCRB_K_BASE);
    diff = $signed({sample_i[15], sample_i, 27'h0}) - r_reg.acc;
    if (!dcc_w[`RCRB_B_FRZ]) begin
      r_next.acc = r_reg.acc + (diff >>> sh);
    end
    r_next.corr = 16'h0000 - r_reg.acc[42:27];

    // output formatting
    o = y_w;
    if (fmt_w[`RCRB_B_INV]) begin
      o = ~o;
    end
    if (fmt_w[1:0] != `RCRB_FMT_TWOS) begin
      o[15] = ~o[15];
    end
    r_next.den = !fmt_w[`RCRB_B_DIS];
    r_next.dat = fmt_w[`RCRB_B_DIS] ? 16'h0000 : o;

    // threshold flag with dwell hysteresis
    if (mag_w > thr_upper_i) begin
      r_next.fd  = 1'b1;
      r_next.dwl = 16'h0000;
    end else if (r_reg.fd && (mag_w < thr_lower_i)) begin
      if (({1'b0, r_reg.dwl} + 17'h00001) >= {1'b0, dwell_i}) begin
        r_next.fd  = 1'b0;
        r_next.dwl = 16'h0000;
      end else begin
        r_next.dwl = r_reg.dwl + 16'h0001;
      end
    end else begin
      r_next.dwl = 16'h0000;
    end
    if (frc_w) begin
      r_next.pin = fval_w;
    end else if (fdc_w[`RCRB_B_FUNC]) begin
      r_next.pin = overrange_i;
    end else begin
      r_next.pin = fdc_w[`RCRB_B_FDEN] && r_reg.fd;
    end

    // noise shaper tuning range depends on bandwidth mode
    r_next.ns_ok = r_reg.act[`RCRB_I_NSC][`RCRB_B_NSWIDE] ?
                   (r_reg.act[`RCRB_I_NST][5:0] < `RCRB_NS_N33) :
                   (r_reg.act[`RCRB_I_NST][5:0] < `RCRB_NS_N22);

    // checksum over the link fields held here, modulo 256
    r_next.sum = r_reg.act[`RCRB_I_MFO] + {5'h00, fmt_w[7:5]};

    // staged writes; transfer copies them into the active set
    if (reg_wr_i && dec_w[4]) begin
      r_next.stg[dec_w[3:0]] = reg_wdata_i;
    end
    if (upd_w) begin
      r_next.act   = r_next.stg;
      r_next.armed = r_next.stg[`RCRB_I_SYN][`RCRB_B_SRMODE];
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.stg[`RCRB_I_EMP] <= `RCRB_R_EMP;
      r_reg.act[`RCRB_I_EMP] <= `RCRB_R_EMP;
      r_reg.stg[`RCRB_I_DRV] <= `RCRB_R_ZERO;
      r_reg.act[`RCRB_I_DRV] <= `RCRB_R_ZERO;
      r_reg.lk_pll <= 1'b1;
      r_reg.lk_ser <= 1'b1;
      r_reg.ns_ok  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign reg_rdata_o            = r_reg.rd;
  assign reg_rvalid_o           = r_reg.rv;
  assign sample_o               = r_reg.dat;
  assign sample_en_o            = r_reg.den;
  assign threshold_flag_pin_o   = r_reg.pin;
  assign adc_power_down_o       = r_reg.pd_adc;
  assign adc_standby_o          = r_reg.sb_adc;
  assign link_pll_en_o          = r_reg.lk_pll;
  assign link_ser_en_o          = r_reg.lk_ser;
  assign link_clk_en_o          = r_reg.lk_ser;
  assign link_rst_o             = r_reg.lk_rst;
  assign driver_power_down_o    = r_reg.act[`RCRB_I_DRV][`RCRB_B_DRVPD];
  assign link_realign_o         = r_reg.rlg;
  assign divider_reset_o        = r_reg.drst;
  assign cs_assign_o            = r_reg.act[`RCRB_I_FMT][7:5];
  assign multiframe_phase_offset_o          = r_reg.act[`RCRB_I_MFO][4:0];
  assign emphasis_o             = r_reg.act[`RCRB_I_EMP];
  // shaper sits outside; it bypasses itself while this is low
  assign noise_shaper_en_o      = r_reg.act[`RCRB_I_NSC][`RCRB_B_NSEN];
  assign noise_shaper_wide_o    = r_reg.act[`RCRB_I_NSC][`RCRB_B_NSWIDE];
  assign noise_shaper_tune_o    = r_reg.act[`RCRB_I_NST][5:0];
  assign noise_shaper_tune_ok_o = r_reg.ns_ok;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_pin_full_pd: assert property (
    power_down_pin_i && !pwr_w[`RCRB_B_EXTSB] |=> adc_power_down_o && !link_pll_en_o)
    else $error("pin did not give full power-down");

  a_link_sb_pin: assert property (
    power_down_pin_i && pwr_w[`RCRB_B_EXTSB] && pwr_w[3:2] == 2'b00 && !upd_w
    |=> link_ser_en_o == !$past(pwr_w[`RCRB_B_LNKSB]))
    else $error("link standby on pin wrong");

  a_link_pd_mode: assert property (
    !power_down_pin_i && pwr_w[3:2] == `RCRB_PM_PD |=> !link_pll_en_o && link_rst_o)
    else $error("link power-down mode wrong");

  a_adc_sb_mode: assert property (
    !power_down_pin_i && pwr_w[1:0] == `RCRB_PM_SB |=> adc_standby_o && !adc_power_down_o)
    else $error("converter standby mode wrong");

  a_out_disable: assert property (
    fmt_w[`RCRB_B_DIS] |=> !sample_en_o && sample_o == 16'h0000)
    else $error("output not suppressed");

  a_plain_path: assert property (
    fmt_w[4:0] == 5'h01 && !dcc_w[`RCRB_B_DCEN] && !upd_w |=> sample_o == $past(sample_i))
    else $error("plain data path altered");

  a_div_every: assert property (
    sr_rise_w && !syn_w[`RCRB_B_SRMODE] |=> divider_reset_o)
    else $error("divider reset missed");

  a_div_once: assert property (
    sr_rise_w && syn_w[`RCRB_B_SRMODE] && !r_reg.armed |=> !divider_reset_o)
    else $error("divider reset repeated");

  a_sysref_gate: assert property (
    !syn_w[`RCRB_B_SREN] && !upd_w |=> !divider_reset_o [*2])
    else $error("disabled sysref acted");

  a_flag_force: assert property (
    frc_w |=> threshold_flag_pin_o == $past(fval_w))
    else $error("forced flag value wrong");

  a_flag_set: assert property (
    mag_w > thr_upper_i |=> r_reg.fd)
    else $error("flag not set above threshold");

  a_xfer_apply: assert property (
    upd_w |=> r_reg.act == r_reg.stg)
    else $error("transfer did not apply");

  a_dc_read: assert property (
    reg_rd_i && reg_addr_i == `RCRB_A_DCH |=> reg_rvalid_o && reg_rdata_o == 8'($past(corr_w) >> 8))
    else $error("dc high byte read wrong");

  a_dc_hold: assert property (
    dcc_w[`RCRB_B_FRZ] |=> r_reg.acc == $past(r_reg.acc))
    else $error("dc estimate moved while frozen");

  a_dc_sum: assert property (
    dcc_w[`RCRB_B_DCEN] && fmt_w[4:0] == 5'h01 |=> sample_o == 16'($past(sample_i) + $past(corr_w)))
    else $error("dc correction not added");

  // codes above the top one must integrate exactly like the top one
  a_dc_clip: assert property (
    !dcc_w[`RCRB_B_FRZ] && dcc_w[5:2] > `RCRB_K_MAX
    |=> r_reg.acc == $past(r_reg.acc) +
        (($signed({$past(sample_i[15]), $past(sample_i), 27'h0}) - $past(r_reg.acc)) >>> 27))
    else $error("dc bandwidth code not clipped");

  a_sync_gate: assert property (
    !syn_w[`RCRB_B_SYEN] && !syn_w[`RCRB_B_RLSR] |=> !link_realign_o)
    else $error("disabled sync request acted");

endmodule
`default_nettype wire

// ### bench/rcrb_top_tb.sv
// self-checking testbench of the receiver control register bank
`default_nettype none
module rcrb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o;
  logic        reg_rvalid_o;
  logic        power_down_pin_i = 1'b0;
  logic        sysref_i = 1'b0;
  logic        sync_request_n_i = 1'b1;
  logic [15:0] sample_i = 16'h0000;
  logic        overrange_i = 1'b0;
  logic [14:0] thr_upper_i = 15'h1000;
  logic [14:0] thr_lower_i = 15'h0800;
  logic [15:0] dwell_i = 16'h0004;
  logic [15:0] sample_o;
  logic        sample_en_o, threshold_flag_pin_o, adc_power_down_o, adc_standby_o;
  logic        link_pll_en_o, link_ser_en_o, link_clk_en_o, link_rst_o, driver_power_down_o;
  logic        link_realign_o, divider_reset_o;
  logic [2:0]  cs_assign_o;
  logic [4:0]  multiframe_phase_offset_o;
  logic [7:0]  emphasis_o;
  logic        noise_shaper_en_o, noise_shaper_wide_o, noise_shaper_tune_ok_o;
  logic [5:0]  noise_shaper_tune_o;
  int          err_total = 0;
  int          n_tests = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  rcrb_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .power_down_pin_i(power_down_pin_i), .sysref_i(sysref_i),
    .sync_request_n_i(sync_request_n_i), .sample_i(sample_i), .overrange_i(overrange_i),
    .thr_upper_i(thr_upper_i), .thr_lower_i(thr_lower_i), .dwell_i(dwell_i), .sample_o(sample_o),
    .sample_en_o(sample_en_o), .threshold_flag_pin_o(threshold_flag_pin_o),
    .adc_power_down_o(adc_power_down_o), .adc_standby_o(adc_standby_o), .link_pll_en_o(link_pll_en_o),
    .link_ser_en_o(link_ser_en_o), .link_clk_en_o(link_clk_en_o), .link_rst_o(link_rst_o),
    .driver_power_down_o(driver_power_down_o), .link_realign_o(link_realign_o),
    .divider_reset_o(divider_reset_o), .cs_assign_o(cs_assign_o), .multiframe_phase_offset_o(multiframe_phase_offset_o),
    .emphasis_o(emphasis_o), .noise_shaper_en_o(noise_shaper_en_o), .noise_shaper_wide_o(noise_shaper_wide_o),
    .noise_shaper_tune_o(noise_shaper_tune_o), .noise_shaper_tune_ok_o(noise_shaper_tune_ok_o));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  // staged value becomes active only on the transfer write
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    wr(8'hff, 8'h01);
    cyc(3);
  endtask

  task automatic rdq(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    chk("rvalid", 16'h0001, {15'h0, reg_rvalid_o});
    q = reg_rdata_o;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    rdq(a, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map();
    rd(8'ha8, 8'h04, "emphasis reset");
    rd(8'h80, 8'h00, "driver reset");
    rd(8'h41, 8'h00, "dc low reset");
    rd(8'h50, 8'h00, "unmapped read");
    chk("drv pd", 16'h0000, {15'h0, driver_power_down_o});
    wr(8'h80, 8'h02);
    chk("drv staged", 16'h0000, {15'h0, driver_power_down_o});
    rd(8'hff, 8'h00, "transfer idle");
    put(8'hff, 8'h01);
    chk("drv pd on", 16'h0001, {15'h0, driver_power_down_o});
    wr(8'h8b, 8'h03);
    put(8'h14, 8'h20);
    wr(8'h79, 8'haa);
    rd(8'h79, 8'h04, "lane sum");
    chk("cs bits", 16'h0001, {13'h0, cs_assign_o});
    chk("multiframe_phase_offset", 16'h0003, {11'h0, multiframe_phase_offset_o});
    chk("emphasis", 16'h0004, {8'h00, emphasis_o});
    wr(8'h77, 8'h5a);
    rd(8'h77, 8'h5a, "scratch");
    $display("test reset_map done");
  endtask

  task automatic t_format();
    logic [7:0]  m [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h10};
    logic [16:0] e [5] = '{17'h19234, 17'h11234, 17'h16dcb, 17'h1edcb, 17'h00000};
    sample_i = 16'h1234;
    for (int i = 0; i < 5; i++) begin
      put(8'h14, m[i]);
      chk("sample", e[i][15:0], sample_o);
      chk("sample en", {15'h0, e[i][16]}, {15'h0, sample_en_o});
    end
    put(8'h14, 8'h01);
    $display("test format done");
  endtask

  task automatic t_power();
    logic [7:0] m [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h20, 8'h30};
    logic [6:0] e [8] = '{7'b0001110, 7'b0101110, 7'b0011110, 7'b0000001, 7'b0001001,
                          7'b1100001, 7'b1011110, 7'b1011001};
    for (int i = 0; i < 8; i++) begin
      power_down_pin_i = e[i][6];
      put(8'h08, m[i]);
      chk("power outs", {10'h0, e[i][5:0]}, {10'h0, adc_power_down_o, adc_standby_o, link_pll_en_o,
          link_ser_en_o, link_clk_en_o, link_rst_o});
    end
    power_down_pin_i = 1'b0;
    put(8'h08, 8'h00);
    $display("test power done");
  endtask

  task automatic pulse(input logic sr, input logic [1:0] e, input string nm);
    logic [1:0] seen;
    seen = 2'b00;
    sysref_i = sr;
    sync_request_n_i = sr;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      seen = seen | {divider_reset_o, link_realign_o};
    end
    sysref_i = 1'b0;
    sync_request_n_i = 1'b1;
    cyc(3);
    chk(nm, {14'h0, e}, {14'h0, seen});
  endtask

  task automatic t_sync();
    put(8'h3a, 8'h0a);
    pulse(1'b1, 2'b11, "sysref realign");
    pulse(1'b1, 2'b11, "sysref again");
    put(8'h3a, 8'h02);
    pulse(1'b1, 2'b10, "sysref no realign");
    put(8'h3a, 8'h08);
    pulse(1'b1, 2'b00, "sysref gated");
    put(8'h3a, 8'h06);
    pulse(1'b1, 2'b10, "sysref once");
    pulse(1'b1, 2'b00, "sysref not again");
    put(8'h3a, 8'h11);
    pulse(1'b0, 2'b01, "sync realign");
    put(8'h3a, 8'h10);
    pulse(1'b0, 2'b00, "sync gated");
    put(8'h3a, 8'h01);
    pulse(1'b0, 2'b00, "sync normal");
    $display("test sync done");
  endtask

  task automatic t_shaper();
    logic [7:0] c [4] = '{8'h01, 8'h01, 8'h03, 8'h03};
    logic [5:0] w [4] = '{6'd56, 6'd57, 6'd33, 6'd34};
    logic [3:0] e [4] = '{4'b1011, 4'b1010, 4'b1111, 4'b1110};
    for (int i = 0; i < 4; i++) begin
      wr(8'h3c, c[i]);
      put(8'h3e, {2'b00, w[i]});
      chk("shaper", {12'h0, e[i]}, {12'h0, noise_shaper_en_o, noise_shaper_wide_o, noise_shaper_tune_o == w[i],
          noise_shaper_tune_ok_o});
    end
    $display("test shaper done");
  endtask

  task automatic t_flag();
    int n;
    put(8'h45, 8'h01);
    sample_i = 16'h2000;
    cyc(4);
    chk("flag set", 16'h0001, {15'h0, threshold_flag_pin_o});
    sample_i = 16'h0100;
    cyc(2);
    chk("flag dwell", 16'h0001, {15'h0, threshold_flag_pin_o});
    n = 0;
    while (threshold_flag_pin_o !== 1'b0 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("flag dwell cycles", 16'h0003, 16'(n));
    if (threshold_flag_pin_o !== 1'b0) begin
      chk("flag clear", 16'h0000, {15'h0, threshold_flag_pin_o});
      conclude();
    end
    sample_i = 16'h2000;
    put(8'h45, 8'h09);
    chk("flag forced", 16'h0000, {15'h0, threshold_flag_pin_o});
    put(8'h45, 8'h00);
    chk("flag off", 16'h0000, {15'h0, threshold_flag_pin_o});
    overrange_i = 1'b1;
    put(8'h45, 8'h10);
    chk("flag overrange", 16'h0001, {15'h0, threshold_flag_pin_o});
    overrange_i = 1'b0;
    cyc(3);
    chk("flag overrange low", 16'h0000, {15'h0, threshold_flag_pin_o});
    sample_i = 16'h1234;
    $display("test flag done");
  endtask

  task automatic t_dc();
    logic [7:0] l0;
    logic [7:0] h0;
    logic [7:0] l1;
    logic [7:0] h1;
    put(8'h40, 8'h40);
    rdq(8'h41, l0);
    rdq(8'h42, h0);
    cyc(20);
    rdq(8'h41, l1);
    rdq(8'h42, h1);
    chk("dc frozen", {h0, l0}, {h1, l1});
    chk("dc estimated", 16'h0001, {15'h0, {h0, l0} != 16'h0000});
    put(8'h40, 8'h42);
    chk("dc added", sample_i + {h0, l0}, sample_o);
    put(8'h40, 8'h02);
    cyc(40);
    rdq(8'h41, l1);
    rdq(8'h42, h1);
    chk("dc tracks", 16'h0001, {15'h0, {h1, l1} != {h0, l0}});
    put(8'h40, 8'h3c);
    cyc(10);
    $display("test dc done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(6);
    rst_i = 1'b0;
    cyc(1);
    t_reset_map();
    t_format();
    t_power();
    t_sync();
    t_shaper();
    t_flag();
    t_dc();
    conclude();
  end
endmodule
`default_nettype wire
